/* sfd_pkg.sv */
// package of constants for the stack fault diagnostics block
package sfd_pkg;
   // ------------------------------------------------------------
   // register map (word addresses on the plain register port)
   // ------------------------------------------------------------
   localparam logic [7:0] SFD_REG_CTRL      = 8'h00; // enables and clear
   localparam logic [7:0] SFD_REG_PILOT_DLY = 8'h01; // pilot delay in ms
   localparam logic [7:0] SFD_REG_OPEN_CUR  = 8'h02; // open: current activity threshold
   localparam logic [7:0] SFD_REG_OPEN_RMIN = 8'h03; // open: min resistance, micro-ohm
   localparam logic [7:0] SFD_REG_OPEN_CNT  = 8'h04; // open: filter sample count
   localparam logic [7:0] SFD_REG_OPEN_PCT  = 8'h05; // open: trip percent
   localparam logic [7:0] SFD_REG_SHRT_CUR  = 8'h06; // short: current activity threshold
   localparam logic [7:0] SFD_REG_SHRT_VOLT = 8'h07; // short: voltage activity threshold
   localparam logic [7:0] SFD_REG_SHRT_CTC  = 8'h08; // short: current time constant shift
   localparam logic [7:0] SFD_REG_SHRT_VTC  = 8'h09; // short: voltage time constant shift
   localparam logic [7:0] SFD_REG_SHRT_ACT  = 8'h0A; // short: activity (slow) shift
   localparam logic [7:0] SFD_REG_SHRT_RAMP = 8'h0B; // short: ramp (fast) shift
   localparam logic [7:0] SFD_REG_SHRT_CNT  = 8'h0C; // short: filter sample count
   localparam logic [7:0] SFD_REG_SHRT_PCT  = 8'h0D; // short: trip percent
   localparam logic [7:0] SFD_REG_TEMP_LIM  = 8'h0E; // temperature spread limit, degC
   localparam logic [7:0] SFD_REG_STATUS    = 8'h0F; // fault status, read only
   // ------------------------------------------------------------
   // control register bit positions
   // ------------------------------------------------------------
   localparam int SFD_CTRL_PILOT_EN  = 0;
   localparam int SFD_CTRL_SC_CLK_EN = 1;
   localparam int SFD_CTRL_PM_CLK_EN = 2;
   localparam int SFD_CTRL_OPEN_EN   = 3;
   localparam int SFD_CTRL_SHRT_EN   = 4;
   localparam int SFD_CTRL_CLEAR     = 7; // write-one pulse, reads zero
   // ------------------------------------------------------------
   // reset values (typical settings)
   // ------------------------------------------------------------
   localparam logic [31:0] SFD_RST_CTRL      = 32'h0000_0002;
   localparam logic [31:0] SFD_RST_PILOT_DLY = 32'h0000_0064; // 100 ms
   localparam logic [31:0] SFD_RST_OPEN_CNT  = 32'h0000_000A; // 10
   localparam logic [31:0] SFD_RST_PCT       = 32'h0000_0032; // 50
   localparam logic [31:0] SFD_RST_SHRT_CNT  = 32'h0000_0064; // 100
   localparam logic [31:0] SFD_RST_TC_SHIFT  = 32'h0000_0004;
   localparam logic [31:0] SFD_RST_ACT_SHIFT = 32'h0000_000A;
   localparam logic [31:0] SFD_RST_RAMP_SHFT = 32'h0000_0003;
   localparam logic [31:0] SFD_RST_TEMP_LIM  = 32'h0000_000F; // 15 degC
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int SFD_CLK_HZ        = 25000000;
   localparam int SFD_MS_US         = 1000;
   localparam int SFD_CLK_NS        = 40;
   localparam int SFD_MS_CYCLES     = SFD_MS_US * 1000 / SFD_CLK_NS; // 25000 cycles per ms
   localparam int SFD_PILOT_DLY_MIN_MS = 100;
   localparam int SFD_PILOT_DLY_MAX_MS = 5000;
   localparam int SFD_CLK_WIN_LOCAL = 1024; // local cycles per comparison window
   localparam int SFD_CLK_TOL       = 8;    // allowed remote edge deviation
   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int SFD_N_MOD   = 4; // cell monitor modules
   localparam int SFD_N_THERM = 8; // thermistors per module
endpackage : sfd_pkg

/* sfd_stack_fault_diag.sv */
// stack fault diagnostics: fault pilot, clock cross check, shunt and thermistor checks
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module sfd_stack_fault_diag
   import sfd_pkg::*;
(
   input  wire logic                 core_clk_i,
   input  wire logic                 rstn_i,
   // register port
   input  wire logic [7:0]           reg_addr_i,
   input  wire logic [31:0]          reg_wdata_i,
   input  wire logic                 reg_wr_i,
   input  wire logic                 reg_rd_i,
   output logic      [31:0]          reg_rdata_o,
   // overall fault inputs
   input  wire logic                 summary_trip_i,   // stack fault summary trip
   input  wire logic                 system_fault_i,   // system in fault state
   // power module clock reference (a pin, another domain)
   input  wire logic                 pm_clk_ref_i,
   // stack samples
   input  wire logic                 sample_valid_i,
   input  wire logic signed [31:0]   stack_volt_mv_i,
   input  wire logic signed [31:0]   stack_cur_ma_i,
   // thermistors, one byte each, signed degC
   input  wire logic                 temp_valid_i,
   input  wire logic [SFD_N_MOD*SFD_N_THERM*8-1:0] temps_i,
   // outputs
   output logic                      fault_pilot_o,    // active high = contactors may close
   output logic                      pm_contactor_open_o,
   output logic                      supervisor_clock_fault_o,
   output logic                      open_shunt_fault_o,
   output logic                      short_shunt_fault_o,
   output logic                      module_temp_spread_fault_o
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0]  ctrl;
   logic [31:0] pilot_dly, open_cur, open_rmin, open_cnt, open_pct;
   logic [31:0] shrt_cur, shrt_volt, shrt_cnt, shrt_pct, temp_lim;
   logic [4:0]  shrt_ctc, shrt_vtc, shrt_act, shrt_ramp;
   wire         wr_hit_ctrl = reg_wr_i && reg_addr_i == SFD_REG_CTRL;
   // clear is a write-one pulse in the control word, never stored
   wire         clear_req   = wr_hit_ctrl && reg_wdata_i[SFD_CTRL_CLEAR];

   // write path
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl      <= SFD_RST_CTRL[7:0];
         pilot_dly <= SFD_RST_PILOT_DLY;
         open_cur  <= 32'h0000_0000;
         open_rmin <= 32'h0000_0000;
         open_cnt  <= SFD_RST_OPEN_CNT;
         open_pct  <= SFD_RST_PCT;
         shrt_cur  <= 32'h0000_0000;
         shrt_volt <= 32'h0000_0000;
         shrt_ctc  <= SFD_RST_TC_SHIFT[4:0];
         shrt_vtc  <= SFD_RST_TC_SHIFT[4:0];
         shrt_act  <= SFD_RST_ACT_SHIFT[4:0];
         shrt_ramp <= SFD_RST_RAMP_SHFT[4:0];
         shrt_cnt  <= SFD_RST_SHRT_CNT;
         shrt_pct  <= SFD_RST_PCT;
         temp_lim  <= SFD_RST_TEMP_LIM;
      end else if (reg_wr_i) begin
         unique case (reg_addr_i)
            SFD_REG_CTRL:      ctrl      <= {1'b0, reg_wdata_i[6:0]};
            SFD_REG_PILOT_DLY: pilot_dly <= reg_wdata_i;
            SFD_REG_OPEN_CUR:  open_cur  <= reg_wdata_i;
            SFD_REG_OPEN_RMIN: open_rmin <= reg_wdata_i;
            SFD_REG_OPEN_CNT:  open_cnt  <= reg_wdata_i;
            SFD_REG_OPEN_PCT:  open_pct  <= reg_wdata_i;
            SFD_REG_SHRT_CUR:  shrt_cur  <= reg_wdata_i;
            SFD_REG_SHRT_VOLT: shrt_volt <= reg_wdata_i;
            SFD_REG_SHRT_CTC:  shrt_ctc  <= reg_wdata_i[4:0];
            SFD_REG_SHRT_VTC:  shrt_vtc  <= reg_wdata_i[4:0];
            SFD_REG_SHRT_ACT:  shrt_act  <= reg_wdata_i[4:0];
            SFD_REG_SHRT_RAMP: shrt_ramp <= reg_wdata_i[4:0];
            SFD_REG_SHRT_CNT:  shrt_cnt  <= reg_wdata_i;
            SFD_REG_SHRT_PCT:  shrt_pct  <= reg_wdata_i;
            SFD_REG_TEMP_LIM:  temp_lim  <= reg_wdata_i;
            default:           ;
         endcase
      end
   end
   wire pilot_en  = ctrl[SFD_CTRL_PILOT_EN];
   wire sc_clk_en = ctrl[SFD_CTRL_SC_CLK_EN];
   wire pm_clk_en = ctrl[SFD_CTRL_PM_CLK_EN];
   wire open_en   = ctrl[SFD_CTRL_OPEN_EN];
   wire shrt_en   = ctrl[SFD_CTRL_SHRT_EN];

   // ------------------------------------------------------------
   // clock cross check
   // ------------------------------------------------------------
   logic        ref_s1, ref_s2, ref_s3;
   logic [10:0] win_cnt;
   logic [10:0] edge_cnt;
   logic        clk_err;
   wire         ref_rise = ref_s2 & ~ref_s3;
   wire         win_end  = win_cnt == 11'(SFD_CLK_WIN_LOCAL - 1);
   // expected remote edges per window: remote runs at one eighth local nominal
   localparam logic [10:0] SFD_EXP_EDGES = 11'(SFD_CLK_WIN_LOCAL / 8);
   wire         edges_bad = (edge_cnt > SFD_EXP_EDGES + 11'(SFD_CLK_TOL))
                         || (edge_cnt + 11'(SFD_CLK_TOL) < SFD_EXP_EDGES);

   // synchronise the remote clock and count its edges per local window
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ref_s1   <= 1'b0;
         ref_s2   <= 1'b0;
         ref_s3   <= 1'b0;
         win_cnt  <= 11'h000;
         edge_cnt <= 11'h000;
         clk_err  <= 1'b0;
      end else begin
         ref_s1  <= pm_clk_ref_i;
         ref_s2  <= ref_s1;
         ref_s3  <= ref_s2;
         win_cnt <= win_end ? 11'h000 : win_cnt + 11'h001;
         if (win_end) begin
            edge_cnt <= 11'h000;
            clk_err  <= edges_bad;
         end else if (ref_rise) begin
            edge_cnt <= edge_cnt + 11'h001;
         end
      end
   end
   // power module side opens contactors directly, no flag
   assign pm_contactor_open_o = pm_clk_en & clk_err;

   // ------------------------------------------------------------
   // open shunt detector
   // ------------------------------------------------------------
   logic signed [31:0] prev_v, prev_i;
   logic [31:0]        o_total, o_bad;
   logic               open_cond;
   wire signed [31:0]  dv = stack_volt_mv_i - prev_v;
   wire signed [31:0]  di = stack_cur_ma_i - prev_i;
   wire [31:0]         abs_i  = stack_cur_ma_i[31] ? 32'(-stack_cur_ma_i) : stack_cur_ma_i;
   wire [31:0]         abs_dv = dv[31] ? 32'(-dv) : dv;
   wire [31:0]         abs_di = di[31] ? 32'(-di) : di;
   wire                o_use  = open_en && sample_valid_i && abs_i > open_cur;
   // resistance mV/mA scaled to micro-ohm: dv*1e6 < rmin*di, done at 64 bits
   wire [63:0]         o_lhs  = 64'(abs_dv) * 64'd1000000;
   wire [63:0]         o_rhs  = 64'(open_rmin) * 64'(abs_di);
   wire                o_faulty = o_lhs < o_rhs;
   wire                o_full = o_total + 32'h1 >= open_cnt;
   wire [63:0]         o_bad_pct = 64'(o_bad + 32'(o_faulty)) * 64'd100;
   wire [63:0]         o_need    = 64'(open_pct) * 64'(o_total + 32'h1);

   // accumulate a window of active samples, judge it when full
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prev_v    <= 32'sh0;
         prev_i    <= 32'sh0;
         o_total   <= 32'h0;
         o_bad     <= 32'h0;
         open_cond <= 1'b0;
      end else begin
         if (sample_valid_i) begin
            prev_v <= stack_volt_mv_i;
            prev_i <= stack_cur_ma_i;
         end
         if (!open_en) begin
            o_total   <= 32'h0;
            o_bad     <= 32'h0;
            open_cond <= 1'b0;
         end else if (o_use) begin
            if (o_full) begin
               o_total   <= 32'h0;
               o_bad     <= 32'h0;
               open_cond <= o_bad_pct >= o_need;
            end else begin
               o_total <= o_total + 32'h1;
               o_bad   <= o_bad + 32'(o_faulty);
            end
         end
      end
   end

   // ------------------------------------------------------------
   // short shunt detector
   // ------------------------------------------------------------
   logic signed [31:0] lp_i, lp_v, slow_v, fast_v;
   logic [31:0]        s_total, s_bad;
   logic               short_cond;
   wire signed [31:0]  act_v   = fast_v - slow_v;
   wire [31:0]         abs_act = act_v[31] ? 32'(-act_v) : act_v;
   wire [31:0]         abs_lpi = lp_i[31] ? 32'(-lp_i) : lp_i;
   wire                s_active = abs_act > shrt_volt;
   wire                s_use    = shrt_en && sample_valid_i && s_active;
   wire                s_faulty = abs_lpi < shrt_cur;
   wire                s_full   = s_total + 32'h1 >= shrt_cnt;
   wire [63:0]         s_bad_pct = 64'(s_bad + 32'(s_faulty)) * 64'd100;
   wire [63:0]         s_need    = 64'(shrt_pct) * 64'(s_total + 32'h1);

   // first-order filters, time constant as a power-of-two shift
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lp_i   <= 32'sh0;
         lp_v   <= 32'sh0;
         slow_v <= 32'sh0;
         fast_v <= 32'sh0;
      end else if (sample_valid_i) begin
         lp_i   <= lp_i + ((stack_cur_ma_i - lp_i) >>> shrt_ctc);
         lp_v   <= lp_v + ((stack_volt_mv_i - lp_v) >>> shrt_vtc);
         slow_v <= slow_v + ((lp_v - slow_v) >>> shrt_act);
         fast_v <= fast_v + ((lp_v - fast_v) >>> shrt_ramp);
      end
   end

   // count uncorrelated samples while voltage is active
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_total    <= 32'h0;
         s_bad      <= 32'h0;
         short_cond <= 1'b0;
      end else if (!shrt_en) begin
         s_total    <= 32'h0;
         s_bad      <= 32'h0;
         short_cond <= 1'b0;
      end else if (s_use) begin
         if (s_full) begin
            s_total    <= 32'h0;
            s_bad      <= 32'h0;
            short_cond <= s_bad_pct >= s_need;
         end else begin
            s_total <= s_total + 32'h1;
            s_bad   <= s_bad + 32'(s_faulty);
         end
      end else if (!s_active) begin
         short_cond <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // thermistor spread per module
   // ------------------------------------------------------------
   logic [SFD_N_MOD-1:0] spread_over;
   genvar gm;
   generate
      for (gm = 0; gm < SFD_N_MOD; gm++) begin : g_mod
         logic signed [7:0] t_min, t_max;
         // find extremes of one module's thermistors
         always_comb begin
            t_min = temps_i[gm*SFD_N_THERM*8 +: 8];
            t_max = t_min;
            for (int k = 1; k < SFD_N_THERM; k++) begin
               if ($signed(temps_i[(gm*SFD_N_THERM+k)*8 +: 8]) < t_min)
                  t_min = temps_i[(gm*SFD_N_THERM+k)*8 +: 8];
               if ($signed(temps_i[(gm*SFD_N_THERM+k)*8 +: 8]) > t_max)
                  t_max = temps_i[(gm*SFD_N_THERM+k)*8 +: 8];
            end
         end
         wire [8:0] spread = 9'(10'(t_max) - 10'(t_min));
         assign spread_over[gm] = 32'(spread) > temp_lim;
      end
   endgenerate
   logic temp_cond;
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i)
         temp_cond <= 1'b0;
      else if (temp_valid_i)
         temp_cond <= |spread_over;
   end

   // ------------------------------------------------------------
   // latched faults, set wins over clear
   // ------------------------------------------------------------
   logic f_clk, f_open, f_short, f_temp;
   wire  clk_cond = sc_clk_en & clk_err;
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         f_clk   <= 1'b0;
         f_open  <= 1'b0;
         f_short <= 1'b0;
         f_temp  <= 1'b0;
      end else begin
         f_clk   <= clk_cond   | (f_clk   & ~clear_req);
         f_open  <= open_cond  | (f_open  & ~clear_req);
         f_short <= short_cond | (f_short & ~(clear_req & ~s_active));
         f_temp  <= temp_cond  | (f_temp  & ~clear_req);
      end
   end
   assign supervisor_clock_fault_o   = f_clk;
   assign open_shunt_fault_o         = f_open;
   assign short_shunt_fault_o        = f_short;
   assign module_temp_spread_fault_o = f_temp;

   // ------------------------------------------------------------
   // fault pilot: delayed follow of overall fault
   // ------------------------------------------------------------
   wire        diag_fault = f_clk | f_open | f_short | f_temp;
   wire        fault_now  = system_fault_i | diag_fault | (pilot_en & summary_trip_i);
   logic [31:0] ms_cnt;
   logic [31:0] dly_ms;
   logic        pilot;
   wire         ms_tick = ms_cnt == 32'(SFD_MS_CYCLES - 1);
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ms_cnt <= 32'h0;
         dly_ms <= 32'h0;
         pilot  <= 1'b0;
      end else if (fault_now == ~pilot) begin
         ms_cnt <= 32'h0;
         dly_ms <= 32'h0;
      end else begin
         ms_cnt <= ms_tick ? 32'h0 : ms_cnt + 32'h1;
         if (ms_tick) begin
            if (dly_ms + 32'h1 >= pilot_dly) begin
               pilot  <= ~fault_now;
               dly_ms <= 32'h0;
            end else begin
               dly_ms <= dly_ms + 32'h1;
            end
         end
      end
   end
   // output sent to power module over the stack bus
   assign fault_pilot_o = pilot & ~system_fault_i;

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i)
         reg_rdata_o <= 32'h0;
      else if (reg_rd_i) begin
         unique case (reg_addr_i)
            SFD_REG_CTRL:      reg_rdata_o <= {24'h0, ctrl};
            SFD_REG_PILOT_DLY: reg_rdata_o <= pilot_dly;
            SFD_REG_OPEN_CUR:  reg_rdata_o <= open_cur;
            SFD_REG_OPEN_RMIN: reg_rdata_o <= open_rmin;
            SFD_REG_OPEN_CNT:  reg_rdata_o <= open_cnt;
            SFD_REG_OPEN_PCT:  reg_rdata_o <= open_pct;
            SFD_REG_SHRT_CUR:  reg_rdata_o <= shrt_cur;
            SFD_REG_SHRT_VOLT: reg_rdata_o <= shrt_volt;
            SFD_REG_SHRT_CTC:  reg_rdata_o <= {27'h0, shrt_ctc};
            SFD_REG_SHRT_VTC:  reg_rdata_o <= {27'h0, shrt_vtc};
            SFD_REG_SHRT_ACT:  reg_rdata_o <= {27'h0, shrt_act};
            SFD_REG_SHRT_RAMP: reg_rdata_o <= {27'h0, shrt_ramp};
            SFD_REG_SHRT_CNT:  reg_rdata_o <= shrt_cnt;
            SFD_REG_SHRT_PCT:  reg_rdata_o <= shrt_pct;
            SFD_REG_TEMP_LIM:  reg_rdata_o <= temp_lim;
            SFD_REG_STATUS:    reg_rdata_o <= {26'h0, pilot, clk_err, f_temp, f_short,
                                               f_open, f_clk};
            default:           reg_rdata_o <= 32'h0;
         endcase
      end else
         reg_rdata_o <= 32'h0;
   end
endmodule : sfd_stack_fault_diag

/* sfd_checker.sv */
// assertions on pilot, fault latching and status readback
`timescale 1ns/1ps
module sfd_checker
   import sfd_pkg::*;
(
   input wire logic        core_clk_i,
   input wire logic        rstn_i,
   input wire logic [7:0]  reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic        system_fault_i,
   input wire logic        temp_valid_i,
   input wire logic        fault_pilot_o,
   input wire logic        supervisor_clock_fault_o,
   input wire logic        open_shunt_fault_o,
   input wire logic        short_shunt_fault_o,
   input wire logic        module_temp_spread_fault_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   wire logic       clr_wr = reg_wr_i && reg_addr_i == SFD_REG_CTRL && reg_wdata_i[SFD_CTRL_CLEAR];
   wire logic [3:0] flt    = {module_temp_spread_fault_o, short_shunt_fault_o,
                              open_shunt_fault_o, supervisor_clock_fault_o};
   sequence s_stat_rd; reg_rd_i && reg_addr_i == SFD_REG_STATUS ##1 1'b1; endsequence
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   property p_pilot_low; system_fault_i |-> !fault_pilot_o; endproperty
   property p_pilot_rise; $rose(fault_pilot_o) |-> $past(flt) == 4'h0; endproperty
   property p_status; s_stat_rd |-> reg_rdata_o[3:0] == $past(flt); endproperty
   property p_clk_hold; $fell(supervisor_clock_fault_o) |-> $past(clr_wr); endproperty
   property p_open_hold; $fell(open_shunt_fault_o) |-> $past(clr_wr); endproperty
   property p_shrt_hold; $fell(short_shunt_fault_o) |-> $past(clr_wr); endproperty
   property p_temp_hold; $fell(module_temp_spread_fault_o) |-> $past(clr_wr); endproperty
   property p_temp_set;
      $rose(module_temp_spread_fault_o) |-> $past(temp_valid_i) || $past(temp_valid_i, 2);
   endproperty
   a_pilot_low: assert property (p_pilot_low)
      else $error("pilot high in fault state");
   a_pilot_rise: assert property (p_pilot_rise)
      else $error("pilot rose with a latched fault");
   a_status: assert property (p_status)
      else $error("status bits differ from fault outputs");
   a_clk_hold: assert property (p_clk_hold)
      else $error("clock fault dropped without clear");
   a_open_hold: assert property (p_open_hold)
      else $error("open shunt fault dropped without clear");
   a_shrt_hold: assert property (p_shrt_hold)
      else $error("short shunt fault dropped without clear");
   a_temp_hold: assert property (p_temp_hold)
      else $error("temperature fault dropped without clear");
   a_temp_set: assert property (p_temp_set)
      else $error("temperature fault set without sample");
endmodule : sfd_checker
bind sfd_stack_fault_diag sfd_checker u_chk (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .system_fault_i(system_fault_i),
   .temp_valid_i(temp_valid_i), .fault_pilot_o(fault_pilot_o),
   .supervisor_clock_fault_o(supervisor_clock_fault_o), .open_shunt_fault_o(open_shunt_fault_o),
   .short_shunt_fault_o(short_shunt_fault_o),
   .module_temp_spread_fault_o(module_temp_spread_fault_o));

/* sfd_pm_model.sv */
// power module model: clock reference and contactor coil drive
`timescale 1ns/1ps
module sfd_pm_model (
   input  wire logic slow_i,
   input  wire logic fault_pilot_i,
   input  wire logic pm_open_i,
   output logic      pm_clk_ref_o,
   output logic      coil_o
);
   // free running reference, one eighth of core rate, or slower on request
   initial begin
      pm_clk_ref_o = 1'b0;
      #7;
      forever #(slow_i ? 200 : 160) pm_clk_ref_o = ~pm_clk_ref_o;
   end
   // coil energised only while the pilot allows it and no clock error opens it
   assign coil_o = fault_pilot_i && !pm_open_i;
endmodule : sfd_pm_model

/* tb.sv */
// testbench of the stack fault diagnostics block
`timescale 1ns/1ps
module tb
   import sfd_pkg::*;
;
   logic core_clk_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0, sys_flt = 0, slow = 0;
   logic tv = 0, rd_d = 0, trip = 1, sv = 0, pilot, pm_open, coil, clk_ref;
   logic signed [31:0] vv = 0, cv = 0;
   logic [7:0] reg_addr_i = 0;
   logic [31:0] wd = 0, rdata;
   logic [SFD_N_MOD*SFD_N_THERM*8-1:0] temps = 0;
   logic [63:0] ent, exp_q[$];
   int seed = 4447, bad_count = 0, cmp_count = 0, cyc = 0;
   logic [7:0] ra [8] = '{SFD_REG_CTRL, SFD_REG_PILOT_DLY, SFD_REG_OPEN_CNT, SFD_REG_SHRT_CNT,
                          SFD_REG_OPEN_PCT, SFD_REG_SHRT_PCT, SFD_REG_TEMP_LIM, 8'h20};
   logic [31:0] rv [8] = '{SFD_RST_CTRL, SFD_RST_PILOT_DLY, SFD_RST_OPEN_CNT, SFD_RST_SHRT_CNT,
                           SFD_RST_PCT, SFD_RST_PCT, SFD_RST_TEMP_LIM, 32'h0};
   always #20 core_clk_i = ~core_clk_i;
   sfd_stack_fault_diag dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(wd), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata),
      .summary_trip_i(trip), .system_fault_i(sys_flt), .pm_clk_ref_i(clk_ref),
      .sample_valid_i(sv), .stack_volt_mv_i(vv), .stack_cur_ma_i(cv),
      .temp_valid_i(tv), .temps_i(temps), .fault_pilot_o(pilot), .pm_contactor_open_o(pm_open),
      .supervisor_clock_fault_o(), .open_shunt_fault_o(), .short_shunt_fault_o(),
      .module_temp_spread_fault_o());
   sfd_pm_model u_pm (.slow_i(slow), .fault_pilot_i(pilot), .pm_open_i(pm_open),
      .pm_clk_ref_o(clk_ref), .coil_o(coil));
   // ------------------------------------------------------------
   // comparison, verdict and bus tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("wrong value at %0t: got %h exp %h", $time, s, e);
      end
   endtask : chk
   task automatic complete_run;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : complete_run
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i); reg_wr_i <= 1; reg_addr_i <= a; wd <= d;
      @(posedge core_clk_i); reg_wr_i <= 0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge core_clk_i); reg_rd_i <= 1; reg_addr_i <= a; exp_q.push_back({m, e & m});
      @(posedge core_clk_i); reg_rd_i <= 0;
   endtask : rd
   // one module gets spread sp, all others stay within 3 degC
   task automatic send_temps(input int sp);
      int mi;
      logic [7:0] b;
      logic [255:0] t;
      mi = $random(seed) & 3;
      b = 8'h14 + 8'($random(seed) & 7);
      for (int i = 0; i < 32; i++) t[i*8 +: 8] = b + 8'($random(seed) & 3);
      t[mi*64 +: 8] = b;
      t[mi*64+56 +: 8] = b + 8'(sp);
      @(posedge core_clk_i); tv <= 1; temps <= t;
      @(posedge core_clk_i); tv <= 0;
   endtask : send_temps
   // read data checked the cycle after each strobe, in issue order
   always @(posedge core_clk_i) begin
      rd_d <= reg_rd_i;
      if (rd_d) begin
         ent = exp_q.pop_front();
         chk(rdata & ent[63:32], ent[31:0]);
      end
      cyc++;
      if (cyc >= 70000) begin
         bad_count++;
         complete_run();
      end
   end
   // main sequence
   initial begin
      repeat (2) @(posedge core_clk_i);
      rstn_i <= 1;
      for (int i = 0; i < 8; i++) rd(ra[i], 32'hFFFF_FFFF, rv[i]);
      $display("reset values done");
      wr(SFD_REG_PILOT_DLY, 32'h1);
      wr(SFD_REG_CTRL, 32'h2);
      repeat (25100) @(posedge core_clk_i);
      chk(pilot, 1);
      chk(coil, 1);
      rd(SFD_REG_STATUS, 32'h2F, 32'h20);
      sys_flt <= 1; trip <= 0;
      @(negedge core_clk_i); chk(pilot, 0);
      chk(coil, 0);
      @(posedge core_clk_i); sys_flt <= 0;
      $display("pilot done");
      send_temps(15); rd(SFD_REG_STATUS, 32'h8, 32'h0);
      send_temps(16); rd(SFD_REG_STATUS, 32'h8, 32'h8);
      send_temps(0); rd(SFD_REG_STATUS, 32'h8, 32'h8);
      wr(SFD_REG_CTRL, 32'h83); rd(SFD_REG_STATUS, 32'h8, 32'h0);
      $display("temperature done");
      slow <= 1; repeat (2200) @(posedge core_clk_i);
      rd(SFD_REG_STATUS, 32'h1, 32'h1);
      slow <= 0; repeat (2200) @(posedge core_clk_i);
      wr(SFD_REG_CTRL, 32'h83); rd(SFD_REG_STATUS, 32'h1, 32'h0);
      wr(SFD_REG_CTRL, 32'h85); slow <= 1; repeat (2200) @(posedge core_clk_i);
      chk(pm_open, 1);
      chk(coil, 0);
      rd(SFD_REG_STATUS, 32'h1, 32'h0);
      trip <= 1; repeat (25100) @(posedge core_clk_i);
      chk(pilot, 0);
      $display("clock check done");
      wr(SFD_REG_OPEN_RMIN, 32'h1); wr(SFD_REG_SHRT_CUR, 32'h1000); wr(SFD_REG_CTRL, 32'h18);
      sv <= 1; vv <= 32'sh0010_0000;
      repeat (120) @(posedge core_clk_i) cv <= ($random(seed) & 255) + 1;
      sv <= 0; rd(SFD_REG_STATUS, 32'h6, 32'h6);
      wr(SFD_REG_CTRL, 32'h90); wr(SFD_REG_CTRL, 32'h90);
      rd(SFD_REG_STATUS, 32'h6, 32'h4);
      repeat (2) @(posedge core_clk_i);
      $display("shunt done");
      complete_run();
   end
endmodule : tb
